/* File: efc_pkg.sv */
// Constants, register map and state encodings for the enhanced flow-control UART block
`default_nettype none
// Behaviour
// R1: Swap bit clear makes the scratch location an ordinary read/write byte.
// R2: Swap bit set: scratch reads give FIFO count, writes load mode select.
// R3: Trigger-select bit steers trigger and count registers: 0 receive, 1 transmit.
// R4: Bits 3:2 pick transmit flow characters: none, first, second or both pairs; the code sends the second pair for 01 and the first pair for 10.
// R5: Bits 1:0 pick receive matching; 11 matches either or both pairs by transmit mode.
// R6: Dual modes send and match the two flow characters as consecutive characters.
// R7: Software clears all flow selection bits before programming a new setting.
// R8: Enhanced-enable gates writes to the enhanced bits and fractional divisor.
// R9: Flow selection bits 3:0 change only while enhanced-enable is set.
// R10: Reset clears every gated enhanced bit for legacy behaviour.
// R11: Software should leave enhanced-enable set in normal operation.
// R12: Special detect compares each received character with second off-character.
// R13: Compare bit 0 lines up with the received character's least significant bit.
// R14: Special detect with second-pair matching drops the off-character and interrupts.
// R15: Auto RTS interrupts at trigger, deasserts above upper level, reasserts below lower.
// R16: Software asserts RTS through modem control before auto RTS takes effect.
// R17: Without auto RTS the RTS pin follows the modem control bit.
// R18: Auto CTS stops transmission while CTS is high, resumes when low.
// R19: Automatic address mode uses the second off-character as address value.
// R20: Divisors start at high 0x00, low 0x01 at power-up only.
// R21: Modem status reset reads lower bits zero, upper bits from inputs.
// R22: Reset values of status, scratch and pins; interrupt output three-stated.
// R23: CTS deassertion lets the current character finish; next waits for CTS.
package efc_pkg;
	// Register indexes on the register port
	localparam logic [4:0] A_IER  = 5'h00;
	localparam logic [4:0] A_ISR  = 5'h01;
	localparam logic [4:0] A_FCR  = 5'h02;
	localparam logic [4:0] A_LCR  = 5'h03;
	localparam logic [4:0] A_MCR  = 5'h04;
	localparam logic [4:0] A_LSR  = 5'h05;
	localparam logic [4:0] A_MSR  = 5'h06;
	localparam logic [4:0] A_SPR  = 5'h07;
	localparam logic [4:0] A_FDIV = 5'h08;
	localparam logic [4:0] A_DIVL = 5'h09;
	localparam logic [4:0] A_DIVH = 5'h0a;
	localparam logic [4:0] A_TRG  = 5'h0b;
	localparam logic [4:0] A_FEATURE_CONTROL = 5'h0c;
	localparam logic [4:0] A_EFR  = 5'h0d;
	localparam logic [4:0] A_ON1  = 5'h0e;
	localparam logic [4:0] A_ON2  = 5'h0f;
	localparam logic [4:0] A_OFF1 = 5'h10;
	localparam logic [4:0] A_OFF2 = 5'h11;
	// Field positions
	localparam int FEATURE_CONTROL_SWAP   = 6;
	localparam int FEATURE_CONTROL_TXSEL  = 7;
	localparam int EFR_ENH     = 4;
	localparam int EFR_SPECIAL = 5;
	localparam int EFR_ARTS    = 6;
	localparam int EFR_ACTS    = 7;
	localparam int MCR_DTR     = 0;
	localparam int MCR_RTS     = 1;
	localparam int MCR_IRQ_OE  = 3;
	localparam int IER_TRIG    = 0;
	localparam int IER_SPECIAL = 5;
	localparam int ENHANCED_MODE_SELECT_ADDR   = 0;
	localparam int FDIV_SPLIT  = 6;
	localparam int FDIV_RXSEL  = 7;
	// Bits held against change while enhanced-enable is clear
	localparam logic [7:0] LOCK_IER = 8'hf0;
	localparam logic [7:0] LOCK_ISR = 8'h30;
	localparam logic [7:0] LOCK_FCR = 8'h38;
	localparam logic [7:0] LOCK_MCR = 8'he0;
	// Reset values
	localparam logic [7:0] SPR_RST  = 8'hff;
	localparam logic [7:0] DIVL_RST = 8'h01;
	localparam logic [7:0] DIVH_RST = 8'h00;
	localparam logic [3:0] PIN_IDLE = 4'hf;
	// RTS hysteresis in characters, indexed by the two low feature-control bits
	localparam logic [3:0][7:0] HYST_TAB = {8'h08, 8'h06, 8'h04, 8'h00};
	// Bits after the start bit: eight data bits and one stop bit
	localparam logic [3:0] BITS_AFTER_START = 4'h9;
	// Transmit sequencer states
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_PAIR = 2'b01,
		TX_WAIT = 2'b10
	} tx_state_t;
endpackage
`default_nettype wire

/* File: uart_char_shifter.sv */
// Serial shifter sending one start, eight data and one stop bit per character
`default_nettype none
module uart_char_shifter (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	// Character request
	input  wire logic        i_start,
	input  wire logic [7:0]  i_char,
	input  wire logic [15:0] i_bit_cycles,
	// Line and status
	output logic             o_txd,
	output logic             o_busy
);
	typedef struct packed {
		logic [8:0]  sh;
		logic [3:0]  bits;
		logic [15:0] cnt;
		logic        txd;
		logic        busy;
	} shift_state_t;

	shift_state_t q;
	shift_state_t n;
	logic [15:0]  period;

	// A zero divisor would stall the line, so it counts as one cycle
	assign period = (i_bit_cycles == 16'h0000) ? 16'h0001 : i_bit_cycles;

	// Start request is only honoured while idle; the character always completes
	always_comb begin
		n = q;
		if (!q.busy) begin
			if (i_start) begin
				n.sh   = {1'b1, i_char};
				n.bits = efc_pkg::BITS_AFTER_START;
				n.cnt  = period - 16'h0001;
				n.txd  = 1'b0;
				n.busy = 1'b1;
			end
		end else if (q.cnt != 16'h0000) begin
			n.cnt = q.cnt - 16'h0001;
		end else if (q.bits == 4'h0) begin
			n.busy = 1'b0;
		end else begin
			n.txd  = q.sh[0];
			n.sh   = {1'b1, q.sh[8:1]};
			n.bits = q.bits - 4'h1;
			n.cnt  = period - 16'h0001;
		end
	end

	// Line idles high from reset
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			q     <= '0;
			q.txd <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign o_txd  = q.txd;
	assign o_busy = q.busy;
endmodule // uart_char_shifter
`default_nettype wire

/* File: uart_efc.sv */
// Enhanced feature control of a deep-FIFO UART: flow control, special characters, locks
`default_nettype none
module uart_efc #(
	parameter int unsigned LEVEL_W = 7
) (
	// Clock and resets
	input  wire logic               i_core_clk,
	input  wire logic               i_rstn,
	input  wire logic               i_por_n,
	// Register port
	input  wire logic [4:0]         i_addr,
	input  wire logic [7:0]         i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	output logic [7:0]              o_rdata,
	// Receiver character stream and receive FIFO
	input  wire logic               i_rx_valid,
	input  wire logic [7:0]         i_rx_char,
	input  wire logic               i_rx_addr_bit,
	input  wire logic [LEVEL_W-1:0] i_rx_level,
	output logic                    o_rxf_push,
	output logic [7:0]              o_rxf_char,
	output logic                    o_addr_match,
	// Transmit data source
	input  wire logic               i_thr_valid,
	input  wire logic [7:0]         i_thr_char,
	input  wire logic [LEVEL_W-1:0] i_tx_level,
	output logic                    o_thr_take,
	// Serial and modem pins, modem inputs ordered cd, ri, dsr, cts
	output logic                    o_txd,
	input  wire logic [3:0]         i_modem_n,
	output logic                    o_rts_n,
	output logic                    o_dtr_n,
	// Interrupt and configuration outputs
	output logic                    o_irq,
	output logic                    o_irq_oe,
	output logic [7:0]              o_fifo_ctrl,
	output logic [7:0]              o_trig_rx,
	output logic [7:0]              o_trig_tx,
	output logic [15:0]             o_div_tx,
	output logic [15:0]             o_div_rx
);
	if (LEVEL_W < 1 || LEVEL_W > 8) begin : g_bad_level
		$error("LEVEL_W must lie between 1 and 8");
	end

	typedef struct packed {
		logic [7:0] interrupt_enable, fifo_control, line_control, modem_control, scratch_byte, enhanced_mode_select, trg_rx, trg_tx;
		logic [7:0] feature_control, enhanced_feature_control, on1, on2, off1, off2, fdiv;
		logic [1:0] isr_flag;
		logic [3:0] msr_wr, msr_delta, sync1, sync2, sync3, modem;
		logic [7:0] rdata, prev, tx_char, rxf_char;
		logic       prev_vld, halted, off_sent, rts_hi, trig_seen;
		logic       irq, irq_oe, rts_n, dtr_n;
		logic       tx_start, thr_take, rxf_push, addr_match;
		efc_pkg::tx_state_t tx_state;
	} efc_state_t;

	typedef struct packed {
		logic [7:0] tx_lo, tx_hi, rx_lo, rx_hi;
	} div_state_t;

	efc_state_t q, n;
	div_state_t dq, dn;
	logic       rst_all_n, busy, enh, cts_ok, sw_tx, pending;
	logic       want_off, want_on, m_on, m_off, special, trig_hit;
	logic [7:0] rx_lvl, tx_lvl, hyst, rd_val;
	logic [8:0] upper, lower_sum;
	logic [3:0] stable;

	// Gated write: locked bits keep their old value while enhanced-enable is clear
	function automatic logic [7:0] gated_wr(input logic [7:0] old_v, input logic [7:0] new_v,
			input logic [7:0] lock, input logic en);
		gated_wr = en ? new_v : ((old_v & lock) | (new_v & ~lock));
	endfunction

	// Flow character match for one kind (on or off) under the receive mode
	function automatic logic flow_match(input logic [7:0] c, input logic [7:0] a,
			input logic [7:0] b, input logic [7:0] p, input logic pv,
			input logic [1:0] rxm, input logic [1:0] txm);
		case (rxm)
			2'b10: flow_match = (c == a);
			2'b01: flow_match = (c == b);
			2'b11: begin
				if (txm == 2'b10 || txm == 2'b01) begin
					flow_match = (c == a) || (c == b);
				end else begin
					flow_match = pv && (p == a) && (c == b); // see R6
				end
			end
			default: flow_match = 1'b0;
		endcase
	endfunction

	// Power-up reset also clears the state the reset pin clears
	assign rst_all_n = i_rstn & i_por_n;
	assign enh       = q.enhanced_feature_control[efc_pkg::EFR_ENH];
	assign rx_lvl    = 8'(i_rx_level);
	assign tx_lvl    = 8'(i_tx_level);
	assign hyst      = efc_pkg::HYST_TAB[q.feature_control[1:0]];
	assign upper     = {1'b0, q.trg_rx} + {1'b0, hyst};
	assign lower_sum = {1'b0, rx_lvl} + {1'b0, hyst};
	// Only starts are gated, so a character in flight always completes
	assign cts_ok    = !(q.enhanced_feature_control[efc_pkg::EFR_ACTS] && q.modem[0]); // see R18, R23
	assign sw_tx     = (q.enhanced_feature_control[3:2] != 2'b00); // see R4
	assign want_off  = sw_tx && !q.off_sent && (rx_lvl >= q.trg_rx);
	assign want_on   = sw_tx && q.off_sent && (lower_sum < {1'b0, q.trg_rx});
	assign trig_hit  = q.enhanced_feature_control[efc_pkg::EFR_ARTS] && (rx_lvl >= q.trg_rx);
	// Whole-byte equality keeps bit 0 aligned to the character's first data bit
	assign special   = q.enhanced_feature_control[efc_pkg::EFR_SPECIAL] && (i_rx_char == q.off2); // see R12, R13

	// Receive flow matching, single or two consecutive characters
	always_comb begin
		m_on  = i_rx_valid && flow_match(i_rx_char, q.on1, q.on2, q.prev, q.prev_vld,
				q.enhanced_feature_control[1:0], q.enhanced_feature_control[3:2]); // see R5
		m_off = i_rx_valid && flow_match(i_rx_char, q.off1, q.off2, q.prev, q.prev_vld,
				q.enhanced_feature_control[1:0], q.enhanced_feature_control[3:2]); // see R5
	end

	// Read multiplexer; unmapped and write-only locations read zero
	always_comb begin
		pending = |(q.isr_flag & {q.interrupt_enable[efc_pkg::IER_TRIG], q.interrupt_enable[efc_pkg::IER_SPECIAL]});
		case (i_addr)
			efc_pkg::A_IER:  rd_val = q.interrupt_enable;
			efc_pkg::A_ISR:  rd_val = {2'b00, q.isr_flag, 3'b000, ~pending};
			efc_pkg::A_FCR:  rd_val = q.fifo_control;
			efc_pkg::A_LCR:  rd_val = q.line_control;
			efc_pkg::A_MCR:  rd_val = q.modem_control;
			efc_pkg::A_LSR:  rd_val = {1'b0, (tx_lvl == 8'h00) && !busy, tx_lvl == 8'h00,
					4'h0, rx_lvl != 8'h00};
			efc_pkg::A_MSR:  rd_val = {~q.modem, q.msr_delta}; // see R21
			efc_pkg::A_SPR:  begin
				if (q.feature_control[efc_pkg::FEATURE_CONTROL_SWAP]) begin
					rd_val = q.feature_control[efc_pkg::FEATURE_CONTROL_TXSEL] ? tx_lvl : rx_lvl; // see R2, R3
				end else begin
					rd_val = q.scratch_byte; // see R1
				end
			end
			efc_pkg::A_FDIV: rd_val = q.fdiv;
			efc_pkg::A_DIVL: rd_val = q.fdiv[efc_pkg::FDIV_RXSEL] ? dq.rx_lo : dq.tx_lo;
			efc_pkg::A_DIVH: rd_val = q.fdiv[efc_pkg::FDIV_RXSEL] ? dq.rx_hi : dq.tx_hi;
			efc_pkg::A_FEATURE_CONTROL: rd_val = q.feature_control;
			efc_pkg::A_EFR:  rd_val = q.enhanced_feature_control;
			efc_pkg::A_ON1:  rd_val = q.on1;
			efc_pkg::A_ON2:  rd_val = q.on2;
			efc_pkg::A_OFF1: rd_val = q.off1;
			efc_pkg::A_OFF2: rd_val = q.off2;
			default:         rd_val = 8'h00;
		endcase
	end

	// Next state of registers, receive path, flow state and transmit sequencer
	always_comb begin
		n  = q;
		dn = dq;
		stable = ~(q.sync2 ^ q.sync3);
		n.rdata = i_rd ? rd_val : 8'h00;
		// Register writes
		if (i_wr) begin
			case (i_addr)
				efc_pkg::A_IER:  n.interrupt_enable = gated_wr(q.interrupt_enable, i_wdata, efc_pkg::LOCK_IER, enh); // see R8
				efc_pkg::A_FCR:  n.fifo_control = gated_wr(q.fifo_control, i_wdata, efc_pkg::LOCK_FCR, enh); // see R8
				efc_pkg::A_MCR:  n.modem_control = gated_wr(q.modem_control, i_wdata, efc_pkg::LOCK_MCR, enh); // see R8
				efc_pkg::A_LCR:  n.line_control = i_wdata;
				efc_pkg::A_MSR:  n.msr_wr = i_wdata[7:4];
				efc_pkg::A_SPR:  begin
					if (q.feature_control[efc_pkg::FEATURE_CONTROL_SWAP]) begin
						n.enhanced_mode_select = i_wdata; // see R2
					end else begin
						n.scratch_byte = i_wdata; // see R1
					end
				end
				efc_pkg::A_FDIV: n.fdiv = enh ? i_wdata : q.fdiv; // see R8
				efc_pkg::A_TRG:  begin
					if (q.feature_control[efc_pkg::FEATURE_CONTROL_TXSEL]) begin
						n.trg_tx = i_wdata; // see R3
					end else begin
						n.trg_rx = i_wdata; // see R3
					end
				end
				efc_pkg::A_FEATURE_CONTROL: n.feature_control = i_wdata;
				efc_pkg::A_EFR:  n.enhanced_feature_control = {i_wdata[7:4], enh ? i_wdata[3:0] : q.enhanced_feature_control[3:0]}; // see R9
				efc_pkg::A_ON1:  n.on1 = i_wdata;
				efc_pkg::A_ON2:  n.on2 = i_wdata;
				efc_pkg::A_OFF1: n.off1 = i_wdata;
				efc_pkg::A_OFF2: n.off2 = i_wdata;
				default:         n.interrupt_enable = q.interrupt_enable;
			endcase
		end
		// Divisors: split flag picks one generator, select 1 without split writes none
		if (i_wr && (i_addr == efc_pkg::A_DIVL || i_addr == efc_pkg::A_DIVH)) begin
			if (!q.fdiv[efc_pkg::FDIV_RXSEL] || q.fdiv[efc_pkg::FDIV_SPLIT]) begin
				if (!q.fdiv[efc_pkg::FDIV_RXSEL]) begin
					if (i_addr == efc_pkg::A_DIVL) dn.tx_lo = i_wdata;
					else dn.tx_hi = i_wdata;
				end
				if (!q.fdiv[efc_pkg::FDIV_SPLIT] || q.fdiv[efc_pkg::FDIV_RXSEL]) begin
					if (i_addr == efc_pkg::A_DIVL) dn.rx_lo = i_wdata;
					else dn.rx_hi = i_wdata;
				end
			end
		end
		// Interrupt flags: reading clears, a hardware set in the same cycle wins
		if (i_wr && i_addr == efc_pkg::A_ISR) begin
			// Both writable status bits sit under the lock mask
			n.isr_flag = enh ? i_wdata[5:4] : q.isr_flag; // see R8
		end else if (i_rd && i_addr == efc_pkg::A_ISR) begin
			n.isr_flag = 2'b00;
		end
		if (i_rx_valid && (special || m_off)) begin
			n.isr_flag[0] = 1'b1; // see R12, R14
		end
		n.trig_seen = trig_hit;
		if (trig_hit && !q.trig_seen) begin
			n.isr_flag[1] = 1'b1; // see R15
		end
		n.irq    = |(n.isr_flag & {q.interrupt_enable[efc_pkg::IER_TRIG], q.interrupt_enable[efc_pkg::IER_SPECIAL]});
		n.irq_oe = q.modem_control[efc_pkg::MCR_IRQ_OE];
		// Modem inputs: three stages, a change counts once stages two and three agree
		n.sync1 = i_modem_n;
		n.sync2 = q.sync1;
		n.sync3 = q.sync2;
		n.modem = (q.sync2 & stable) | (q.modem & ~stable);
		n.msr_delta = ((i_rd && i_addr == efc_pkg::A_MSR) ? 4'h0 : q.msr_delta)
				| (n.modem ^ q.modem);
		// Receive path: flow characters are consumed, others go to the FIFO
		n.rxf_push   = i_rx_valid && !m_on && !m_off; // see R12, R14
		n.rxf_char   = i_rx_char;
		n.addr_match = i_rx_valid && i_rx_addr_bit && q.enhanced_mode_select[efc_pkg::ENHANCED_MODE_SELECT_ADDR]
				&& (i_rx_char == q.off2); // see R19
		if (i_rx_valid) begin
			n.prev     = i_rx_char;
			n.prev_vld = 1'b1;
		end
		if (q.enhanced_feature_control[1:0] == 2'b00) begin
			n.halted = 1'b0;
		end else if (m_off) begin
			n.halted = 1'b1;
		end else if (m_on) begin
			n.halted = 1'b0;
		end
		// RTS: manual from modem control, or hysteresis band when automatic
		if (!q.enhanced_feature_control[efc_pkg::EFR_ARTS]) begin
			n.rts_n = ~q.modem_control[efc_pkg::MCR_RTS]; // see R17
		end else begin
			if ({1'b0, rx_lvl} >= upper) begin
				n.rts_hi = 1'b1; // see R15
			end else if (lower_sum < {1'b0, q.trg_rx}) begin
				n.rts_hi = 1'b0; // see R15
			end
			// Auto control only acts once software has asserted RTS
			n.rts_n = q.modem_control[efc_pkg::MCR_RTS] ? n.rts_hi : 1'b1; // see R16
		end
		n.dtr_n = ~q.modem_control[efc_pkg::MCR_DTR];
		// Transmit sequencer: flow characters take priority over data
		n.tx_start = 1'b0;
		n.thr_take = 1'b0;
		case (q.tx_state)
			efc_pkg::TX_IDLE: begin
				if (cts_ok && !busy) begin
					if (want_off || want_on) begin
						n.tx_start = 1'b1;
						n.off_sent = want_off;
						if (q.enhanced_feature_control[3:2] == 2'b01) begin
							n.tx_char = want_off ? q.off2 : q.on2; // see R4
						end else begin
							n.tx_char = want_off ? q.off1 : q.on1; // see R4
						end
						n.tx_state = (q.enhanced_feature_control[3:2] == 2'b11) ? efc_pkg::TX_PAIR
								: efc_pkg::TX_WAIT; // see R6
					end else if (i_thr_valid && !q.halted) begin
						n.tx_start = 1'b1;
						n.thr_take = 1'b1;
						n.tx_char  = i_thr_char;
						n.tx_state = efc_pkg::TX_WAIT;
					end
				end
			end
			efc_pkg::TX_PAIR: begin
				if (cts_ok && !busy && !q.tx_start) begin
					n.tx_start = 1'b1;
					n.tx_char  = q.off_sent ? q.off2 : q.on2; // see R6
					n.tx_state = efc_pkg::TX_WAIT;
				end
			end
			efc_pkg::TX_WAIT: begin
				if (!busy && !q.tx_start) begin
					n.tx_state = efc_pkg::TX_IDLE;
				end
			end
			default: n.tx_state = efc_pkg::TX_IDLE;
		endcase
	end

	// Main state: reset pin or power-up; enhanced bits come up cleared
	always_ff @(posedge i_core_clk or negedge rst_all_n) begin
		if (!rst_all_n) begin
			q       <= '0; // see R10, R22
			q.scratch_byte   <= efc_pkg::SPR_RST;
			q.sync1 <= efc_pkg::PIN_IDLE;
			q.sync2 <= efc_pkg::PIN_IDLE;
			q.sync3 <= efc_pkg::PIN_IDLE;
			q.modem <= efc_pkg::PIN_IDLE;
			q.rts_n <= 1'b1;
			q.dtr_n <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// Divisors survive the reset pin and only start over at power-up
	always_ff @(posedge i_core_clk or negedge i_por_n) begin
		if (!i_por_n) begin
			dq.tx_lo <= efc_pkg::DIVL_RST; // see R20
			dq.tx_hi <= efc_pkg::DIVH_RST;
			dq.rx_lo <= efc_pkg::DIVL_RST;
			dq.rx_hi <= efc_pkg::DIVH_RST;
		end else begin
			dq <= dn;
		end
	end

	// Serial line, bit period set by the transmit divisor
	uart_char_shifter u_shifter (
		.i_core_clk   (i_core_clk),
		.i_rstn       (rst_all_n),
		.i_start      (q.tx_start),
		.i_char       (q.tx_char),
		.i_bit_cycles ({dq.tx_hi, dq.tx_lo}),
		.o_txd        (o_txd),
		.o_busy       (busy)
	);

	// Outputs straight from state
	assign o_rdata     = q.rdata;
	assign o_rxf_push  = q.rxf_push;
	assign o_rxf_char  = q.rxf_char;
	assign o_addr_match = q.addr_match;
	assign o_thr_take  = q.thr_take;
	assign o_rts_n     = q.rts_n;
	assign o_dtr_n     = q.dtr_n;
	assign o_irq       = q.irq;
	assign o_irq_oe    = q.irq_oe;
	assign o_fifo_ctrl = q.fifo_control;
	assign o_trig_rx   = q.trg_rx;
	assign o_trig_tx   = q.trg_tx;
	assign o_div_tx    = {dq.tx_hi, dq.tx_lo};
	assign o_div_rx    = {dq.rx_hi, dq.rx_lo};

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!rst_all_n);

	sequence s_spr_write;
		i_wr && i_addr == efc_pkg::A_SPR && !q.feature_control[efc_pkg::FEATURE_CONTROL_SWAP];
	endsequence
	sequence s_spr_read;
		i_rd && i_addr == efc_pkg::A_SPR && !q.feature_control[efc_pkg::FEATURE_CONTROL_SWAP];
	endsequence

	a_scratch_plain_rw: assert property (s_spr_write ##1 s_spr_read |=>
			o_rdata == $past(i_wdata, 2)) else $error("scratch byte lost"); // see R1
	a_count_swap_read: assert property (i_rd && i_addr == efc_pkg::A_SPR
			&& q.feature_control[efc_pkg::FEATURE_CONTROL_SWAP] |=> o_rdata == ($past(q.feature_control[efc_pkg::FEATURE_CONTROL_TXSEL])
			? $past(tx_lvl) : $past(rx_lvl))) else $error("count read wrong"); // see R2
	a_efr_flow_lock: assert property (i_wr && i_addr == efc_pkg::A_EFR && !enh |=>
			$stable(q.enhanced_feature_control[3:0])) else $error("flow bits changed while locked"); // see R9
	a_ier_upper_lock: assert property (i_wr && i_addr == efc_pkg::A_IER && !enh |=>
			q.interrupt_enable[7:4] == $past(q.interrupt_enable[7:4])) else $error("locked enables changed"); // see R8
	a_cts_stops_tx: assert property (q.enhanced_feature_control[efc_pkg::EFR_ACTS] && q.modem[0] |=>
			!q.tx_start) else $error("character started with CTS high"); // see R18
	a_special_kept: assert property (i_rx_valid && special && q.enhanced_feature_control[1:0] == 2'b00 ||
			i_rx_valid && special && q.enhanced_feature_control[1:0] == 2'b10 && i_rx_char != q.off1
			&& i_rx_char != q.on1 |=> o_rxf_push && q.isr_flag[0])
			else $error("special character not stored"); // see R12
	a_second_off_drop: assert property (i_rx_valid && special && q.enhanced_feature_control[1:0] == 2'b01 |=>
			!o_rxf_push && q.isr_flag[0]) else $error("second off kept"); // see R14
	a_rts_manual_pin: assert property (!q.enhanced_feature_control[efc_pkg::EFR_ARTS] |=>
			o_rts_n == !$past(q.modem_control[efc_pkg::MCR_RTS])) else $error("RTS not manual"); // see R17
	a_dual_off_halt: assert property (i_rx_valid && q.enhanced_feature_control[3:0] == 4'b1111 && q.prev_vld
			&& q.prev == q.off1 && i_rx_char == q.off2 |=> q.halted && !o_rxf_push)
			else $error("dual off not honoured"); // see R6
endmodule // uart_efc
`default_nettype wire

/* File: remote_peer.sv */
// Remote serial peer: sends stream characters, drives CTS, decodes the serial output
`default_nettype none
module remote_peer (
	// Clock
	input  wire logic i_core_clk,
	// Serial line from the block
	input  wire logic i_txd,
	// Character stream and flow pin towards the block
	output logic       o_rx_valid,
	output logic [7:0] o_rx_char,
	output logic       o_cts_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got_q;
	logic [7:0] bits;
	initial begin
		o_rx_valid = 1'b0;
		o_rx_char  = 8'h00;
		o_cts_n    = 1'b0;
	end
	// Released byte is inverted so a stale value never looks valid
	task automatic send(input logic [7:0] ch);
		@(posedge i_core_clk);
		o_rx_valid <= 1'b1;
		o_rx_char  <= ch;
		@(posedge i_core_clk);
		o_rx_valid <= 1'b0;
		o_rx_char  <= ~ch;
	endtask
	// Flow pin moves only just after an edge
	task automatic set_cts(input logic v);
		@(posedge i_core_clk);
		o_cts_n <= v;
	endtask
	// Decoder assumes one clock per bit, the power-up divisor; LSB first
	always begin
		@(posedge i_core_clk);
		if (i_txd === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				@(posedge i_core_clk);
				bits[i] = i_txd;
			end
			@(posedge i_core_clk);
			got_q = bits;
		end
	end
endmodule // remote_peer
`default_nettype wire

/* File: test_uart_efc.sv */
// Self-checking bench for the enhanced flow-control block
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_uart_efc;
	timeunit 1ns;
	timeprecision 1ns;
	logic       i_core_clk, i_rstn, i_por_n, i_wr, i_rd, rxv, push, thv, take, txd, cts_n;
	logic       rts_n, dtr_n, irq_oe, rxa, amatch, irq;
	logic [6:0] rxl, txl;
	logic [4:0] i_addr;
	logic [7:0] i_wdata, rdata, rxc, pch, thc, rv;
	logic [15:0] div_tx;
	int         failures, n_tests, n;
	uart_efc #(.LEVEL_W(7)) u_uart_efc (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
		.i_por_n(i_por_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(rdata), .i_rx_valid(rxv), .i_rx_char(rxc), .i_rx_addr_bit(rxa),
		.i_rx_level(rxl), .o_rxf_push(push), .o_rxf_char(pch), .o_addr_match(amatch),
		.i_thr_valid(thv), .i_thr_char(thc), .i_tx_level(txl), .o_thr_take(take),
		.o_txd(txd), .i_modem_n({3'b111, cts_n}), .o_rts_n(rts_n), .o_dtr_n(dtr_n),
		.o_irq(irq), .o_irq_oe(irq_oe), .o_fifo_ctrl(), .o_trig_rx(), .o_trig_tx(),
		.o_div_tx(div_tx), .o_div_rx());
	remote_peer u_remote_peer (.i_core_clk(i_core_clk), .i_txd(txd), .o_rx_valid(rxv),
		.o_rx_char(rxc), .o_cts_n(cts_n));
	// Clock, 100 ns period
	initial begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = ~i_core_clk;
	end
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		{i_wr, i_addr, i_wdata} <= {1'b1, a, d};
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		{i_rd, i_addr} <= {1'b1, a};
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic t_reset();
		rd(efc_pkg::A_SPR, rv); `CHK(rv, 8'hff)
		rd(efc_pkg::A_ISR, rv); `CHK(rv, 8'h01)
		rd(efc_pkg::A_LSR, rv); `CHK(rv, 8'h60)
		rd(efc_pkg::A_IER, rv); `CHK(rv, 8'h00)
		`CHK({txd, rts_n, dtr_n, irq_oe}, 4'he)
		wr(efc_pkg::A_DIVL, 8'h05);
		@(posedge i_core_clk) i_rstn <= 1'b0;
		@(posedge i_core_clk) i_rstn <= 1'b1;
		#1 `CHK(div_tx, 16'h0005)
		wr(efc_pkg::A_DIVL, 8'h01);
		$display("reset test done");
	endtask
	task automatic t_scratch();
		// Levels stay zero until here so the reset status read sees empty FIFOs
		{rxl, txl} <= {7'h05, 7'h2a};
		wr(efc_pkg::A_SPR, 8'h5a);
		rd(efc_pkg::A_SPR, rv); `CHK(rv, 8'h5a)
		wr(efc_pkg::A_FEATURE_CONTROL, 8'h40);
		rd(efc_pkg::A_SPR, rv); `CHK(rv, 8'h05)
		wr(efc_pkg::A_FEATURE_CONTROL, 8'hc0);
		rd(efc_pkg::A_SPR, rv); `CHK(rv, 8'h2a)
		wr(efc_pkg::A_FEATURE_CONTROL, 8'h00);
		rd(efc_pkg::A_SPR, rv); `CHK(rv, 8'h5a)
		$display("scratch test done");
	endtask
	task automatic t_lock();
		wr(efc_pkg::A_EFR, 8'h0a);
		rd(efc_pkg::A_EFR, rv); `CHK(rv, 8'h00)
		wr(efc_pkg::A_IER, 8'hff);
		rd(efc_pkg::A_IER, rv); `CHK(rv, 8'h0f)
		wr(efc_pkg::A_EFR, 8'h10);
		wr(efc_pkg::A_IER, 8'hff);
		rd(efc_pkg::A_IER, rv); `CHK(rv, 8'hff)
		wr(efc_pkg::A_IER, 8'h00);
		wr(efc_pkg::A_MCR, 8'h03);
		@(posedge i_core_clk) #1 `CHK({rts_n, dtr_n}, 2'b00)
		$display("lock test done");
	endtask
	// Sends one character and judges push and the special flag
	task automatic rx_one(input logic [7:0] c, input logic p, input logic f);
		u_remote_peer.send(c);
		#1 `CHK({push, amatch, irq}, {p, rxa, f})
		if (p) `CHK(pch, c)
		rd(efc_pkg::A_ISR, rv); `CHK(rv[4], f)
	endtask
	task automatic t_special();
		// Swapped scratch write turns on address detection for every later character
		wr(efc_pkg::A_FEATURE_CONTROL, 8'h40);
		wr(efc_pkg::A_SPR, 8'h01);
		wr(efc_pkg::A_FEATURE_CONTROL, 8'h00);
		wr(efc_pkg::A_IER, 8'h20);
		wr(efc_pkg::A_OFF2, 8'h01);
		wr(efc_pkg::A_EFR, 8'h30);
		rx_one(8'h80, 1'b1, 1'b0);
		rx_one(8'h01, 1'b1, 1'b1);
		wr(efc_pkg::A_EFR, 8'h10);
		wr(efc_pkg::A_EFR, 8'h31);
		rxa <= 1'b1;
		rx_one(8'h01, 1'b0, 1'b1);
		wr(efc_pkg::A_EFR, 8'h10);
		rxa <= 1'b0;
		// Dual pair: first off character is kept, the second one halts and flags
		wr(efc_pkg::A_OFF1, 8'h13);
		wr(efc_pkg::A_EFR, 8'h1f);
		rx_one(8'h13, 1'b1, 1'b0);
		rx_one(8'h01, 1'b0, 1'b1);
		wr(efc_pkg::A_EFR, 8'h10);
		$display("special test done");
	endtask
	task automatic t_cts();
		u_remote_peer.set_cts(1'b1);
		wr(efc_pkg::A_EFR, 8'h90);
		repeat (8) @(posedge i_core_clk);
		{thv, thc} <= {1'b1, 8'ha5};
		n = 0;
		repeat (30) @(posedge i_core_clk) if (take !== 1'b0) n++;
		`CHK(n, 0)
		u_remote_peer.set_cts(1'b0);
		for (n = 0; n < 30 && take !== 1'b1; n++) @(posedge i_core_clk);
		thv <= 1'b0;
		repeat (20) @(posedge i_core_clk);
		`CHK(u_remote_peer.got_q, 8'ha5)
		$display("cts test done");
	endtask
	// Watchdog: tests need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge i_core_clk);
		failures++;
		conclude();
	end
	initial begin
		{i_rstn, i_por_n, i_wr, i_rd, thv, i_addr, i_wdata, thc, rxa, rxl, txl} = '0;
		failures = 0;
		n_tests = 0;
		repeat (16) @(posedge i_core_clk);
		{i_rstn, i_por_n} <= 2'b11;
		t_reset();
		t_scratch();
		t_lock();
		t_special();
		t_cts();
		conclude();
	end
endmodule // test_uart_efc
`default_nettype wire
